// >>> hdl/bpi_pkg.sv
// Purpose: Shared constants and types for the bilinear pixel interpolator
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes:   Register offsets are byte addresses on the low address byte
`default_nettype none
package bpi_pkg;
	// Register byte offsets
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_SRC       = 8'h04;
	localparam logic [7:0]  ADDR_RESULT    = 8'h08;
	localparam logic [7:0]  ADDR_STATUS    = 8'h0c;
	// Control layout and reset
	localparam logic [15:0] CTL_WMASK      = 16'h6bff;
	localparam logic [15:0] CTL_RESET_VAL  = 16'h0000;
	localparam int          CTL_RST_BIT    = 10;
	localparam logic [1:0]  MODE_SINGLE_SHOT   = 2'h0;
	localparam logic [1:0]  MODE_PIPELINED_ROW = 2'h1;
	// Pipeline delay in output pixels
	localparam logic [2:0]  DLY_STD_PH0    = 3'h6;
	localparam logic [2:0]  DLY_STD_PH1    = 3'h7;
	localparam logic [2:0]  DLY_FAST_PH0   = 3'h2;
	localparam logic [2:0]  DLY_FAST_PH1   = 3'h3;
	localparam logic [2:0]  DLY_NONE       = 3'h0;
	// Single-shot latency in T-cycles
	localparam int          SHOT_STD_CYC   = 10;
	localparam int          SHOT_FAST_CYC  = 6;
	localparam logic [3:0]  SHOT_STD_LOAD  = 4'(SHOT_STD_CYC - 1);
	localparam logic [3:0]  SHOT_FAST_LOAD = 4'(SHOT_FAST_CYC - 1);
	// Arithmetic
	localparam logic [4:0]  WT_ONE         = 5'h10;
	localparam logic [17:0] RND_HALF       = 18'h00080;
	localparam int          PIX_SHIFT      = 8;
	localparam int          PIX_W          = 8;
	localparam int          FIFO_DEPTH     = 8;
	localparam int          HTRANS_ACT_BIT = 1;
	localparam logic        HRESP_OKAY     = 1'b0;

	typedef struct packed {
		logic       rsv15;
		logic       fast;
		logic       phase;
		logic       rsv12;
		logic       pair;
		logic       rst;
		logic [1:0] mode;
		logic [3:0] v;
		logic [3:0] h;
	} bpi_ctrl_s;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] d;
	} bpi_quad_s;

	typedef struct packed {
		logic [22:0] zero;
		logic [3:0]  fifo_cnt;
		logic [2:0]  dummy;
		logic        busy;
		logic        src_bot;
	} bpi_status_s;

	typedef enum logic [1:0] {EM_IDLE, EM_E0, EM_E1, EM_SHOT} bpi_emit_e;

	typedef struct packed {
		bpi_ctrl_s   ctrl;
		logic        dp_vld;
		logic        dp_wr;
		logic [7:0]  dp_addr;
		logic        rd_done;
		logic        rd_half;
		logic [31:0] rdata;
		logic        src_bot;
		logic [15:0] top;
		logic [15:0] bot;
		logic        prev_vld;
		logic [7:0]  prev_top;
		logic [7:0]  prev_bot;
		bpi_emit_e   em;
		logic [7:0]  pix;
		logic        pix_vld;
		logic [2:0]  dummy;
		logic [3:0]  shot_cnt;
	} bpi_state_s;
endpackage : bpi_pkg
`default_nettype wire

// >>> hdl/bpi_interp.sv
// Purpose: Combinational bilinear weighting of four pixels
// Assumes: Weights are numerators over sixteen
// Notes:   Result rounds half up, then drops eight fraction bits
`default_nettype none
module bpi_interp (
	input  wire bpi_pkg::bpi_quad_s q,
	input  wire logic [3:0]         h,
	input  wire logic [3:0]         v,
	output logic [7:0]              w
);
	import bpi_pkg::*;

	logic [4:0]  hi;
	logic [4:0]  hc;
	logic [4:0]  vi;
	logic [4:0]  vc;
	logic [9:0]  wa;
	logic [9:0]  wb;
	logic [9:0]  wc;
	logic [9:0]  wd;
	logic [17:0] sum;
	logic [17:0] rnd;

	assign hi  = {1'b0, h};
	assign vi  = {1'b0, v};
	assign hc  = WT_ONE - hi;
	assign vc  = WT_ONE - vi;
	assign wa  = hc * vc;
	assign wb  = hi * vc;
	assign wc  = hc * vi;
	assign wd  = hi * vi;
	assign sum = 18'(q.a) * 18'(wa) + 18'(q.b) * 18'(wb)
		+ 18'(q.c) * 18'(wc) + 18'(q.d) * 18'(wd);
	// (R18) Round half up
	assign rnd = sum + RND_HALF;
	assign w   = rnd[PIX_SHIFT +: PIX_W];
endmodule : bpi_interp
`default_nettype wire

// >>> hdl/bpi_fifo.sv
// Purpose: Output pixel FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Flush empties it in one cycle
`default_nettype none
module bpi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic                     clk,
	input  wire logic                     rstn,
	input  wire logic                     flush,
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [WIDTH-1:0]         in_data,
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [WIDTH-1:0]              out_data,
	output logic [$clog2(DEPTH):0]        count
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wp_ff;
	logic [AW-1:0]    rp_ff;
	logic [AW:0]      cnt_ff;
	logic             push;
	logic             pop;

	assign in_ready  = cnt_ff != (AW+1)'(DEPTH);
	assign out_valid = cnt_ff != '0;
	assign out_data  = mem_ff[rp_ff];
	assign count     = cnt_ff;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else if (flush) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wp_ff <= wp_ff + 1'b1;
			end
			if (pop) begin
				rp_ff <= rp_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk) begin
		if (push && !flush) begin
			mem_ff[wp_ff] <= in_data;
		end
	end
endmodule : bpi_fifo
`default_nettype wire

// >>> hdl/bpi_interpolator.sv
// Purpose: Bilinear pixel interpolator with AHB-Lite register access
// Assumes: Word accesses only; low address byte decoded
// Notes:   Result reads wait until a pixel is available
// Behaviour
// (R1) Output is the bilinear blend of A,B,C,D by weights h and v.
// (R2) Control bits 7:4 hold v, bits 3:0 hold h, sixteenths each.
// (R3) Control bits 9:8 pick mode: 00 single-shot, 01 pipelined row.
// (R4) Pipelined mode yields a new pixel every two T-cycles once filled.
// (R5) Pairs arrive top then bottom, leftmost pixel in the low byte.
// (R6) Startup: four passes of two pair writes and two reads.
// (R7) Single-shot: write pairs, wait 10 or 6 cycles, read one result.
// (R8) Writing one to control bit 10 resets the interpolator state.
// (R9) Software resets the interpolator before changing modes.
// (R10) Bit 11 clear gives single pixels; set pairs outputs in row mode.
// (R11) Phase clear: first two outputs form first pair, first in low.
// (R12) Phase set: first output in high byte, low byte invalid.
// (R13) Bit 14 picks standard or fast pipeline depth.
// (R14) Row mode delay is 6, 7, 2 or 3 pixels by depth and phase.
// (R15) Pair mode keeps pixel delay; standard phase 0 gives three bad pairs.
// (R16) Standard, phase set: fourth pair half good, fifth pair fully good.
// (R17) Software writes zero to reserved control bits 15 and 12.
// (R18) Weighted sum rounds half up to eight bits in every mode.
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`default_nettype none
module bpi_interpolator #(
	parameter int DEPTH = bpi_pkg::FIFO_DEPTH
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	import bpi_pkg::*;

	bpi_state_s              s;
	bpi_state_s              n;
	bpi_ctrl_s               nc;
	bpi_quad_s               q0;
	bpi_quad_s               q1;
	bpi_status_s             st;
	logic [7:0]              w0;
	logic [7:0]              w1;
	logic                    f_in_ready;
	logic                    f_out_valid;
	logic                    f_pop;
	logic [PIX_W-1:0]        f_out_data;
	logic [$clog2(DEPTH):0]  f_cnt;
	logic                    soft_rst;
	logic                    wr_bot;
	logic                    wstall;
	logic                    adv;
	logic                    seq;
	logic                    pair_mode;
	logic                    take;
	logic [7:0]              px;

	function automatic logic [2:0] fill_delay(input bpi_ctrl_s c);
		logic [2:0] d;
		d = DLY_NONE;
		if (c.mode == MODE_PIPELINED_ROW) begin
			if (c.fast) begin
				d = c.phase ? DLY_FAST_PH1 : DLY_FAST_PH0;
			end else begin
				d = c.phase ? DLY_STD_PH1 : DLY_STD_PH0;
			end
		end
		return d;
	endfunction : fill_delay

	// (R5) Leftmost pixel in low byte
	assign q0 = '{a: s.prev_top, b: s.top[7:0], c: s.prev_bot, d: s.bot[7:0]};
	assign q1 = '{a: s.top[7:0], b: s.top[15:8], c: s.bot[7:0], d: s.bot[15:8]};

	// (R1) Two blend units
	bpi_interp u_interp0 (
		.q (q0),
		.h (s.ctrl.h),
		.v (s.ctrl.v),
		.w (w0)
	);

	bpi_interp u_interp1 (
		.q (q1),
		.h (s.ctrl.h),
		.v (s.ctrl.v),
		.w (w1)
	);

	bpi_fifo #(
		.WIDTH (PIX_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (hclk),
		.rstn      (hresetn),
		.flush     (soft_rst),
		.in_valid  (s.pix_vld),
		.in_ready  (f_in_ready),
		.in_data   (s.pix),
		.out_valid (f_out_valid),
		.out_ready (f_pop),
		.out_data  (f_out_data),
		.count     (f_cnt)
	);

	// (R3) Mode decode
	assign seq       = s.ctrl.mode == MODE_PIPELINED_ROW;
	assign pair_mode = seq && s.ctrl.pair;
	assign adv       = !s.pix_vld || f_in_ready;
	assign hresp     = HRESP_OKAY;
	assign hrdata    = s.rdata;

	always_comb begin
		n         = s;
		nc        = bpi_ctrl_s'(hwdata[15:0] & CTL_WMASK);
		soft_rst  = 1'b0;
		wr_bot    = 1'b0;
		wstall    = 1'b0;
		f_pop     = 1'b0;
		take      = 1'b0;
		px        = 8'h00;
		st        = '0;
		st.fifo_cnt = 4'(f_cnt);
		st.dummy    = s.dummy;
		st.busy     = s.em != EM_IDLE;
		st.src_bot  = s.src_bot;
		hreadyout = 1'b1;

		if (s.pix_vld && f_in_ready) begin
			n.pix_vld = 1'b0;
		end
		// (R4) Two pixels per row pair write; one for the first pair after reset and one per single-shot
		unique case (s.em)
			EM_IDLE: begin
			end
			EM_E0: begin
				if (adv) begin
					n.pix     = w0;
					n.pix_vld = 1'b1;
					n.em      = EM_E1;
				end
			end
			EM_E1: begin
				if (adv) begin
					n.pix      = w1;
					n.pix_vld  = 1'b1;
					n.em       = EM_IDLE;
					n.prev_vld = 1'b1;
					n.prev_top = s.top[15:8];
					n.prev_bot = s.bot[15:8];
				end
			end
			EM_SHOT: begin
				if (s.shot_cnt != 4'h0) begin
					n.shot_cnt = s.shot_cnt - 4'h1;
				end else if (adv) begin
					n.pix     = w1;
					n.pix_vld = 1'b1;
					n.em      = EM_IDLE;
				end
			end
		endcase

		if (s.dp_vld && s.dp_wr) begin
			unique case (s.dp_addr)
				ADDR_CTRL: begin
					// (R2) Weight and control fields
					n.ctrl = nc;
					n.ctrl.rst = 1'b0;
					soft_rst = hwdata[CTL_RST_BIT];
				end
				ADDR_SRC: begin
					if (!s.src_bot) begin
						n.top     = hwdata[15:0];
						n.src_bot = 1'b1;
					end else if (s.em != EM_IDLE) begin
						wstall = 1'b1;
					end else begin
						wr_bot    = 1'b1;
						n.bot     = hwdata[15:0];
						n.src_bot = 1'b0;
						// (R13) Single-shot latency by depth
						n.shot_cnt = s.ctrl.fast ? SHOT_FAST_LOAD : SHOT_STD_LOAD;
						if (seq) begin
							n.em = s.prev_vld ? EM_E0 : EM_E1;
						end else begin
							n.em = EM_SHOT;
						end
					end
				end
				default: begin
				end
			endcase
			hreadyout = !wstall;
		end else if (s.dp_vld) begin
			hreadyout = s.rd_done;
			if (!s.rd_done) begin
				unique case (s.dp_addr)
					ADDR_CTRL: begin
						n.rdata   = {16'h0000, s.ctrl};
						n.rd_done = 1'b1;
					end
					ADDR_STATUS: begin
						n.rdata   = st;
						n.rd_done = 1'b1;
					end
					ADDR_RESULT: begin
						// (R14) Fill pixels read as indeterminate
						// (R15) (R16) Fills counted per pixel
						if (s.dummy != 3'h0) begin
							take    = 1'b1;
							n.dummy = s.dummy - 3'h1;
						end else if (f_out_valid) begin
							take  = 1'b1;
							px    = f_out_data;
							f_pop = 1'b1;
						end
						// (R10) Single pixel or pair per read
						if (take && pair_mode && !s.rd_half) begin
							n.rdata   = {24'h000000, px};
							n.rd_half = 1'b1;
						end else if (take && pair_mode) begin
							// (R11) First pixel in low byte
							n.rdata   = {16'h0000, px, s.rdata[7:0]};
							n.rd_half = 1'b0;
							n.rd_done = 1'b1;
						end else if (take) begin
							n.rdata   = {24'h000000, px};
							n.rd_done = 1'b1;
						end
					end
					default: begin
						n.rdata   = 32'h00000000;
						n.rd_done = 1'b1;
					end
				endcase
			end
		end

		if (s.dp_vld && hreadyout) begin
			n.dp_vld  = 1'b0;
			n.rd_done = 1'b0;
		end
		if (hready && hsel && htrans[HTRANS_ACT_BIT]) begin
			n.dp_vld  = 1'b1;
			n.dp_wr   = hwrite;
			n.dp_addr = haddr[7:0];
		end

		// (R8) Soft reset clears the pipeline
		if (soft_rst) begin
			n.src_bot  = 1'b0;
			n.prev_vld = 1'b0;
			n.em       = EM_IDLE;
			n.pix_vld  = 1'b0;
			n.shot_cnt = 4'h0;
			n.rd_half  = 1'b0;
			// (R12) Phase adds one fill pixel
			n.dummy    = fill_delay(nc);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s      <= '0;
			s.ctrl <= bpi_ctrl_s'(CTL_RESET_VAL);
			s.em   <= EM_IDLE;
		end else begin
			s <= n;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_fill_std_ph0: assert property ( // (R14)
		soft_rst && nc.mode == MODE_PIPELINED_ROW && !nc.fast && !nc.phase
		|=> s.dummy == 3'h6)
		else $error("standard phase 0 fill count wrong");

	a_fill_fast: assert property ( // (R13)
		soft_rst && nc.mode == MODE_PIPELINED_ROW && nc.fast && !nc.phase
		|=> s.dummy == 3'h2)
		else $error("fast fill count wrong");

	a_fill_phase: assert property ( // (R12)
		soft_rst && nc.mode == MODE_PIPELINED_ROW && !nc.fast && nc.phase
		|=> s.dummy == 3'h7)
		else $error("phase fill count wrong");

	a_shot_nofill: assert property ( // (R3)
		soft_rst && nc.mode == MODE_SINGLE_SHOT |=> s.dummy == 3'h0)
		else $error("single-shot mode has fill pixels");

	a_soft_clear: assert property ( // (R8)
		soft_rst |=> !s.pix_vld && s.em == EM_IDLE && !s.src_bot && f_cnt == '0)
		else $error("soft reset left state behind");

	a_row_two_pix: assert property ( // (R4)
		s.em == EM_E0 && adv |=> s.em == EM_E1 && s.pix_vld)
		else $error("second row pixel not following");

	a_zero_weight: assert property ( // (R1)
		s.ctrl.h == 4'h0 && s.ctrl.v == 4'h0 |-> w1 == q1.a && w0 == q0.a)
		else $error("zero weight does not pass pixel A");

	a_half_round: assert property ( // (R18)
		s.ctrl.v == 4'h0
		|-> w1 == 8'((12'(q1.a) * (12'h010 - 12'(s.ctrl.h))
			+ 12'(q1.b) * 12'(s.ctrl.h) + 12'h008) >> 4))
		else $error("rounding not half up");

	a_single_byte: assert property ( // (R10)
		s.dp_vld && !s.dp_wr && s.rd_done && s.dp_addr == ADDR_RESULT && !pair_mode
		|-> s.rdata[31:8] == 24'h000000)
		else $error("single pixel read has upper bits");

	a_pair_low: assert property ( // (R11)
		s.rd_half && n.rd_done |=> s.rdata[7:0] == $past(s.rdata[7:0]))
		else $error("first pair pixel not kept in low byte");

	a_shot_wait: assert property ( // (R13)
		wr_bot && !seq && !s.ctrl.fast |=> (s.em == EM_SHOT)[*8])
		else $error("single-shot result too early");
endmodule : bpi_interpolator
`default_nettype wire

// >>> hdl/_end.sv
`default_nettype none
`default_nettype wire

// >>> tb/bpi_host_model.sv
// Purpose: Processor-side bus master feeding the interpolator
// Assumes: Single AHB-Lite word transfers, one slave
// Notes:   Released write data is inverted
`default_nettype none
module bpi_host_model import bpi_pkg::*; (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		hsel   = 1'b0;
		haddr  = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = '0;
	end
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= w ? d : ~hwdata;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
		hwdata <= ~hwdata;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(a, 1'b1, d, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		xfer(a, 1'b0, '0, r);
	endtask : rd
	task automatic set_ctrl(input bpi_ctrl_s c);
		c.rsv15 = 1'b0;
		c.rsv12 = 1'b0;
		c.rst   = 1'b1;
		wr(ADDR_CTRL, {16'h0, c});
		c.rst   = 1'b0;
		wr(ADDR_CTRL, {16'h0, c});
	endtask : set_ctrl
	task automatic src(input logic [15:0] t, input logic [15:0] b);
		wr(ADDR_SRC, {16'h0, t});
		wr(ADDR_SRC, {16'h0, b});
	endtask : src
	task automatic shot(input logic [15:0] t, input logic [15:0] b, input logic f,
			output logic [31:0] r);
		src(t, b);
		repeat (f ? 6 : 10) @(posedge hclk);
		rd(ADDR_RESULT, r);
	endtask : shot
endmodule : bpi_host_model
`default_nettype wire

// >>> tb/test_bilinear_pixel_interpolator.sv
// Purpose: Self-checking bench for the bilinear pixel interpolator
// Assumes: Host model drives the register bus
// Notes:   Fill pixels are skipped, real pixels compared
`default_nettype none
module test_bilinear_pixel_interpolator;
	timeunit 1ns;
	timeprecision 1ns;
	import bpi_pkg::*;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rv;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          cyc        = 0;
	bpi_interpolator #(.DEPTH(FIFO_DEPTH)) u_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata));
	bpi_host_model u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	function automatic logic [7:0] blend(input int a, b, c, d, h, v);
		return 8'((a*(16-h)*(16-v) + b*h*(16-v) + c*(16-h)*v + d*h*v + 128) >> 8);
	endfunction : blend
	function automatic logic [7:0] tp(input int i);
		return 8'(16 + 19 * i);
	endfunction : tp
	function automatic logic [7:0] bt(input int i);
		return 8'(200 - 23 * i);
	endfunction : bt
	function automatic logic [7:0] px(input int i);
		return blend(tp(i), tp(i + 1), bt(i), bt(i + 1), 10, 6);
	endfunction : px
	// passes of two writes, two pixels
	task automatic run(input logic f, input logic ph, input logic pr);
		bpi_ctrl_s   c;
		logic [31:0] r;
		int          d;
		int          s;
		c       = '0;
		c.h     = 4'ha;
		c.v     = 4'h6;
		c.mode  = MODE_PIPELINED_ROW;
		c.fast  = f;
		c.phase = ph;
		c.pair  = pr;
		d       = f ? (ph ? 3 : 2) : (ph ? 7 : 6);
		s       = 0;
		u_host.set_ctrl(c);
		u_host.rd(ADDR_STATUS, r);
		chk("status fill", 32'(d) << 2, r);
		for (int k = 0; k < 5; k++) begin
			u_host.src({tp(2*k+1), tp(2*k)}, {bt(2*k+1), bt(2*k)});
			for (int j = 0; j < (pr ? 1 : 2); j++) begin
				u_host.rd(ADDR_RESULT, r);
				for (int q = 0; q < (pr ? 2 : 1); q++) begin
					if (s >= d) chk("pixel", {24'h0, px(s - d)}, {24'h0, r[8*q +: 8]});
					s++;
				end
			end
		end
		$display("test row fast=%0d phase=%0d pair=%0d done", f, ph, pr);
	endtask : run
	task automatic shots();
		bpi_ctrl_s   c;
		logic [31:0] r;
		for (int i = 0; i < 4; i++) begin
			c      = '0;
			c.h    = 4'(i * 5);
			c.v    = 4'(15 - i * 5);
			c.fast = i[0];
			c.mode = {i[1], 1'b0};
			u_host.set_ctrl(c);
			u_host.shot({tp(i+1), tp(i)}, {bt(i+1), bt(i)}, c.fast, r);
			chk("shot", {24'h0, blend(tp(i), tp(i+1), bt(i), bt(i+1), i*5, 15-i*5)}, r);
		end
		$display("test single shot done");
	endtask : shots
	initial begin
		hresetn = 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		u_host.rd(ADDR_CTRL, rv);
		chk("ctrl reset", 32'h0, rv);
		u_host.wr(ADDR_CTRL, 32'h00006fff);
		u_host.rd(ADDR_CTRL, rv);
		chk("ctrl rw", 32'h00006bff, rv);
		u_host.wr(8'h10, 32'h0000ffff);
		u_host.rd(8'h10, rv);
		chk("unmapped", 32'h0, rv);
		$display("test registers done");
		shots();
		for (int m = 0; m < 8; m++) run(m[0], m[1], m[2]);
		chk("hresp", 32'h0, {31'h0, hresp});
		wrap_up();
	end
endmodule : test_bilinear_pixel_interpolator
`default_nettype wire
